// ### hdl/asml_regs.svh
// Register offsets, field positions and reset values of the alarm logic
`ifndef ASML_REGS_SVH
`define ASML_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets on the configuration port
// ----------------------------------------------------------------------
`define ASML_ADDR_W 15
`define ASML_ADDR_SUMMARY 15'h2c0
`define ASML_ADDR_FLAGS 15'h2c1
`define ASML_ADDR_GATE 15'h2c2
`define ASML_ADDR_LANE 15'h2c4

// ----------------------------------------------------------------------
// Field positions shared by alarm_flags and alarm_enable_gate
// ----------------------------------------------------------------------
`define ASML_BIT_FIFO 5
`define ASML_BIT_PLL 4
`define ASML_BIT_LINK 3
`define ASML_BIT_REALIGN 2
`define ASML_BIT_CLKDIV 0
`define ASML_BIT_SUMMARY 0

// Defined alarm bits; reserved bits 7:6 and 1 are excluded
`define ASML_ALARM_BITS 8'h3d

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ASML_RST_FLAGS 8'h3f
`define ASML_RST_GATE 8'h3f
`define ASML_RST_LANE 8'hff

`endif

// ### hdl/asml_pkg.sv
// Types shared by the alarm status and mask logic
package asml_pkg;

    // Register selected by the configuration address
    typedef enum logic [2:0] {
        ASML_SEL_NONE = 3'b000,
        ASML_SEL_SUMMARY = 3'b001,
        ASML_SEL_FLAGS = 3'b010,
        ASML_SEL_GATE = 3'b011,
        ASML_SEL_LANE = 3'b100
    } asml_sel_t;

endpackage : asml_pkg

// ### hdl/asml_sticky_flags.sv
// Bank of sticky write-one-to-clear flags where a set beats a clear
`timescale 1ns/10ps
module asml_sticky_flags #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic softReset,
    input wire logic [WIDTH-1:0] setBits,
    input wire logic [WIDTH-1:0] clearBits,
    output logic [WIDTH-1:0] flags
);

    // ------------------------------------------------------------------
    // Flag storage
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] flags_reg; // Current flag state
    logic [WIDTH-1:0] flags_next; // Next flag state

    // Next state: clear first, then OR in the set so no event is lost
    always_comb begin
        if (softReset) begin
            flags_next = RESET_VALUE;
        end else begin
            flags_next = (flags_reg & ~clearBits) | setBits;
        end
    end

    // Registering only; asynchronous reset loads the constant default
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_reg <= RESET_VALUE;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags = flags_reg;

endmodule : asml_sticky_flags

// ### hdl/asml_alarm_logic.sv
// Alarm status flags, mask gate and summary alarm with register access
`timescale 1ns/10ps
`include "asml_regs.svh"

module asml_alarm_logic
    import asml_pkg::*;
#(
    parameter int LANES = 8
) (
    ref_clk,
    rst_n,
    softReset,
    regAddr,
    regWrEn,
    regWrData,
    regRdEn,
    regRdData,
    serialLinkEnable,
    linkMode64b66b,
    linkInDataState,
    linkRealignEvent,
    laneFifoFault,
    serializerPllLocked,
    sysrefRealignEvent,
    clkDivStateAB,
    clkDivStateCD,
    calStatusSelAlarm,
    calStatusOther,
    calibrationStatusPin
);
    input wire logic ref_clk; // 100 MHz digital clock
    input wire logic rst_n; // Power-on reset, active low
    input wire logic softReset; // Soft reset pulse
    input wire logic [`ASML_ADDR_W-1:0] regAddr; // Configuration port address
    input wire logic regWrEn; // Write strobe, one cycle
    input wire logic [7:0] regWrData; // Write data
    input wire logic regRdEn; // Read strobe, one cycle
    output logic [7:0] regRdData; // Read data, one cycle after strobe
    input wire logic serialLinkEnable; // Serial link enabled
    input wire logic linkMode64b66b; // High when link uses 64B/66B
    input wire logic linkInDataState; // Transmitter in its data state
    input wire logic linkRealignEvent; // FIFO or serializer realignment
    input wire logic [LANES-1:0] laneFifoFault; // Per-lane over/underflow
    input wire logic serializerPllLocked; // Serializer PLL in lock
    input wire logic sysrefRealignEvent; // SYSREF realigned internal clocks
    input wire logic [7:0] clkDivStateAB; // Divider state, channels A and B
    input wire logic [7:0] clkDivStateCD; // Divider state, channels C and D
    input wire logic calStatusSelAlarm; // Pin selection picks the alarm
    input wire logic calStatusOther; // Pin source when alarm not selected
    output logic calibrationStatusPin; // Calibration status output pin

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic asml_sel_t decodeAddr(input logic [`ASML_ADDR_W-1:0] addr);
        if (addr == `ASML_ADDR_SUMMARY) begin
            return ASML_SEL_SUMMARY;
        end else if (addr == `ASML_ADDR_FLAGS) begin
            return ASML_SEL_FLAGS;
        end else if (addr == `ASML_ADDR_GATE) begin
            return ASML_SEL_GATE;
        end else if (addr == `ASML_ADDR_LANE) begin
            return ASML_SEL_LANE;
        end else begin
            return ASML_SEL_NONE;
        end
    endfunction : decodeAddr

    asml_sel_t addrSel; // Register picked by the current address
    assign addrSel = decodeAddr(regAddr);

    // ------------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------------
    logic linkEnable_reg; // Link enable one cycle ago, for startup edge
    logic linkEnable_next;
    logic [7:0] flagSet; // Set requests into alarm_flags
    logic [7:0] flagClear; // Clear requests into alarm_flags
    logic [LANES-1:0] laneClear; // Clear requests into lane register
    logic [7:0] flags; // alarm_flags contents
    logic [LANES-1:0] laneFlags; // per_lane_fifo_fault contents
    logic linkStartup; // First cycle with the link enabled

    assign linkEnable_next = serialLinkEnable;
    assign linkStartup = serialLinkEnable && !linkEnable_reg;

    // Events from the link side are only trusted while the link runs;
    // the clock divider check is independent of the link
    // link-side flags gated
    always_comb begin
        flagSet = 8'h00;
        flagSet[`ASML_BIT_FIFO] = serialLinkEnable && (|laneFifoFault);
        flagSet[`ASML_BIT_PLL] = serialLinkEnable && !serializerPllLocked;
        if (linkMode64b66b) begin
            flagSet[`ASML_BIT_LINK] = linkStartup || (serialLinkEnable && linkRealignEvent);
        end else begin
            flagSet[`ASML_BIT_LINK] = serialLinkEnable && !linkInDataState;
        end
        flagSet[`ASML_BIT_REALIGN] = serialLinkEnable && sysrefRealignEvent;
        flagSet[`ASML_BIT_CLKDIV] = (clkDivStateAB != clkDivStateCD);
    end

    // Write-one-to-clear decode for both flag registers
    always_comb begin
        flagClear = 8'h00;
        laneClear = '0;
        if (regWrEn && addrSel == ASML_SEL_FLAGS) begin
            flagClear = regWrData & `ASML_ALARM_BITS;
        end
        if (regWrEn && addrSel == ASML_SEL_LANE) begin
            laneClear = regWrData[LANES-1:0];
        end
        if (regWrEn && addrSel == ASML_SEL_FLAGS && regWrData[`ASML_BIT_FIFO]) begin
            laneClear = '1;
        end
    end

    // ------------------------------------------------------------------
    // Flag banks
    // ------------------------------------------------------------------
    // sticky until cleared
    asml_sticky_flags #(
        .WIDTH(8),
        .RESET_VALUE(`ASML_RST_FLAGS)
    ) flagBank (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .softReset(softReset),
        .setBits(flagSet),
        .clearBits(flagClear),
        .flags(flags)
    );

    // Per-lane detail; all ones after reset, where alarm_flags resets to 8'h3f
    asml_sticky_flags #(
        .WIDTH(LANES),
        .RESET_VALUE({LANES{1'b1}})
    ) laneBank (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .softReset(softReset),
        .setBits(serialLinkEnable ? laneFifoFault : '0),
        .clearBits(laneClear),
        .flags(laneFlags)
    );

    // ------------------------------------------------------------------
    // Mask gate, summary and read path
    // ------------------------------------------------------------------
    logic [7:0] gate_reg; // alarm_enable_gate
    logic [7:0] gate_next;
    logic [7:0] rdData_reg; // Registered read data
    logic [7:0] rdData_next;
    logic pin_reg; // Registered status pin
    logic pin_next;
    logic alarmSummary; // Summary alarm bit

    // any unmasked flag among the defined alarm bits raises the summary
    assign alarmSummary = |(flags & ~gate_reg & `ASML_ALARM_BITS);

    // Mask is plain read/write; reserved bits are stored as written,
    // since software is expected to rewrite their defaults
    always_comb begin
        gate_next = gate_reg;
        if (softReset) begin
            gate_next = `ASML_RST_GATE;
        end else if (regWrEn && addrSel == ASML_SEL_GATE) begin
            gate_next = regWrData;
        end
    end

    // Read mux; unmapped addresses read as zero
    always_comb begin
        rdData_next = rdData_reg;
        if (regRdEn) begin
            case (addrSel)
                ASML_SEL_SUMMARY: rdData_next = {7'h00, alarmSummary};
                ASML_SEL_FLAGS: rdData_next = flags;
                ASML_SEL_GATE: rdData_next = gate_reg;
                ASML_SEL_LANE: rdData_next = 8'(laneFlags);
                default: rdData_next = 8'h00;
            endcase
        end
    end

    assign pin_next = calStatusSelAlarm ? alarmSummary : calStatusOther;

    // Registering of mask, read data, pin and link enable history
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gate_reg <= `ASML_RST_GATE;
            rdData_reg <= 8'h00;
            pin_reg <= 1'b0;
            linkEnable_reg <= 1'b0;
        end else begin
            gate_reg <= gate_next;
            rdData_reg <= rdData_next;
            pin_reg <= pin_next;
            linkEnable_reg <= linkEnable_next;
        end
    end

    assign regRdData = rdData_reg;
    assign calibrationStatusPin = pin_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence flagsWriteFifo;
        regWrEn && addrSel == ASML_SEL_FLAGS && regWrData[`ASML_BIT_FIFO];
    endsequence

    sequence quietLanes;
        !serialLinkEnable || laneFifoFault == '0;
    endsequence

    chk_summary_value: assert property (
        alarmSummary == (flags[5] && !gate_reg[5] || flags[4] && !gate_reg[4]
        || flags[3] && !gate_reg[3] || flags[2] && !gate_reg[2] || flags[0] && !gate_reg[0]))
        else $error("summary alarm disagrees with flags and mask");
    chk_pin_drive: assert property (
        calStatusSelAlarm |=> calibrationStatusPin == $past(alarmSummary))
        else $error("status pin does not follow summary alarm");
    chk_fifo_set: assert property (
        serialLinkEnable && |laneFifoFault && !softReset |=> flags[5])
        else $error("fifo fault flag not set");
    chk_lane_clear: assert property (
        flagsWriteFifo and quietLanes and !softReset |=> laneFlags == '0)
        else $error("lane bits not cleared by fifo flag clear");
    chk_pll_set: assert property (
        serialLinkEnable && !serializerPllLocked && !softReset |=> flags[4])
        else $error("pll flag not set");
    chk_link_8b10b: assert property (
        serialLinkEnable && !linkMode64b66b && !linkInDataState |=> flags[3])
        else $error("link flag not set outside data state");
    chk_link_64b66b: assert property (
        $rose(serialLinkEnable) && linkMode64b66b && !softReset |=> flags[3])
        else $error("link flag not set on 64b66b startup");
    chk_realign_set: assert property (
        serialLinkEnable && sysrefRealignEvent && !softReset |=> flags[2])
        else $error("realignment flag not set");
    chk_clkdiv_set: assert property (
        clkDivStateAB != clkDivStateCD && !softReset |=> flags[0])
        else $error("clock divider flag not set");
    chk_w1c_clear: assert property (
        regWrEn && addrSel == ASML_SEL_FLAGS && regWrData[0] && !softReset
        && clkDivStateAB == clkDivStateCD |=> !flags[0])
        else $error("write one did not clear clock flag");
    chk_soft_reset: assert property (
        softReset |=> flags == 8'h3f && gate_reg == 8'h3f)
        else $error("soft reset did not restore defaults");
    chk_sticky_hold: assert property (
        flags[2] && !(regWrEn && addrSel == ASML_SEL_FLAGS) |=> flags[2])
        else $error("realignment flag dropped without a clear");
    chk_summary_ro: assert property (
        regRdEn && addrSel == ASML_SEL_SUMMARY |=> regRdData[7:1] == 7'h00
        && regRdData[0] == $past(alarmSummary))
        else $error("summary read shows wrong value");

endmodule : asml_alarm_logic

// ### verification/asml_alarm_logic_tb.sv
// Self-checking testbench for the alarm status flags, mask gate and summary alarm
`timescale 1ns/10ps
`include "asml_regs.svh"
module asml_alarm_logic_tb
    import asml_pkg::*;
;
    // ------------------------------------------------------------------
    // Stimulus and observation signals
    // ------------------------------------------------------------------
    localparam int LANES = 8; // Lane count handed to the design
    localparam int TIMEOUT_CYCLES = 5000; // Whole run needs well under 2000 cycles
    logic ref_clk = 1'b0; // 100 MHz clock
    logic rst_n = 1'b0; // Power-on reset, active low
    logic softReset = 1'b0;
    logic [`ASML_ADDR_W-1:0] regAddr = '0;
    logic regWrEn = 1'b0;
    logic [7:0] regWrData = 8'h00;
    logic regRdEn = 1'b0;
    logic [7:0] regRdData;
    logic serialLinkEnable = 1'b0;
    logic linkMode64b66b = 1'b0;
    logic linkInDataState = 1'b1; // Data state held so the link flag stays quiet
    logic linkRealignEvent = 1'b0;
    logic [LANES-1:0] laneFifoFault = '0;
    logic serializerPllLocked = 1'b1;
    logic sysrefRealignEvent = 1'b0;
    logic [7:0] clkDivStateAB = 8'h5a;
    logic [7:0] clkDivStateCD = 8'h5a; // Equal dividers: no clock alarm
    logic calStatusSelAlarm = 1'b1; // Pin shows the summary alarm
    logic calStatusOther = 1'b0;
    logic calibrationStatusPin;
    int failures = 0; // Mismatches seen
    int nTests = 0; // Comparisons made
    int cycleCount = 0; // Cycles since time zero, for the hang guard
    int causeBits[5] = '{5, 4, 3, 2, 0}; // Flag positions driven by the event table
    // ------------------------------------------------------------------
    // Device under test
    // ------------------------------------------------------------------
    asml_alarm_logic #(.LANES(LANES)) asml_alarm_logic_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .softReset(softReset), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .serialLinkEnable(serialLinkEnable), .linkMode64b66b(linkMode64b66b),
        .linkInDataState(linkInDataState), .linkRealignEvent(linkRealignEvent),
        .laneFifoFault(laneFifoFault), .serializerPllLocked(serializerPllLocked),
        .sysrefRealignEvent(sysrefRealignEvent), .clkDivStateAB(clkDivStateAB),
        .clkDivStateCD(clkDivStateCD), .calStatusSelAlarm(calStatusSelAlarm),
        .calStatusOther(calStatusOther), .calibrationStatusPin(calibrationStatusPin)
    );
    // Free-running clock, 10 ns period
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    // Compare a seen value against the expected one, four-state exact
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        nTests++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    // One-cycle write strobe; the value lands at the strobe edge
    task automatic regWrite(input logic [`ASML_ADDR_W-1:0] addr, input logic [7:0] data);
        @(posedge ref_clk);
        regAddr <= addr;
        regWrData <= data;
        regWrEn <= 1'b1;
        @(posedge ref_clk);
        regWrEn <= 1'b0;
    endtask : regWrite
    // One-cycle read strobe; data is settled just after the following edge
    task automatic expectReg(input logic [`ASML_ADDR_W-1:0] addr, input logic [7:0] exp,
                             input string what);
        @(posedge ref_clk);
        regAddr <= addr;
        regRdEn <= 1'b1;
        @(posedge ref_clk);
        regRdEn <= 1'b0;
        #1 check(regRdData, exp, what);
    endtask : expectReg
    // Raise or drop the condition behind one flag position (6 is the 64B/66B realign)
    task automatic setCause(input int b, input logic on);
        case (b)
            5: laneFifoFault <= on ? 8'h04 : 8'h00;
            4: serializerPllLocked <= ~on;
            3: linkInDataState <= ~on;
            2: sysrefRealignEvent <= on;
            6: linkRealignEvent <= on;
            default: clkDivStateCD <= on ? 8'h5b : 8'h5a;
        endcase
    endtask : setCause
    // Hold a condition for exactly one sampling edge
    task automatic pulseCause(input int b);
        @(posedge ref_clk);
        setCause(b, 1'b1);
        @(posedge ref_clk);
        setCause(b, 1'b0);
    endtask : pulseCause
    task automatic endTest(input string name);
        $display("Test %s done: %0d compares, %0d mismatches", name, nTests, failures);
    endtask : endTest
    // Counts, verdict and end of run
    task automatic summarize();
        $display("Compares %0d, mismatches %0d", nTests, failures);
        if (failures == 0 && nTests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize
    // Hang guard: a stuck run counts as a mismatch
    always @(posedge ref_clk) begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == TIMEOUT_CYCLES) begin
            failures++;
            summarize();
        end
    end
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        // Reset contents, summary masked off, reserved flag bits fixed
        expectReg(`ASML_ADDR_FLAGS, `ASML_RST_FLAGS, "flags reset");
        expectReg(`ASML_ADDR_GATE, `ASML_RST_GATE, "gate reset");
        expectReg(`ASML_ADDR_LANE, `ASML_RST_LANE, "lane reset");
        // Lane detail clears bit by bit on its own address
        regWrite(`ASML_ADDR_LANE, 8'hf0);
        expectReg(`ASML_ADDR_LANE, 8'h0f, "lane w1c");
        expectReg(`ASML_ADDR_SUMMARY, 8'h00, "summary reset");
        endTest("reset");
        // Enable the link, then clear all alarm flags and lanes (reserved bit 1 stays set); zero writes change nothing
        @(posedge ref_clk);
        serialLinkEnable <= 1'b1;
        regWrite(`ASML_ADDR_FLAGS, 8'hff);
        expectReg(`ASML_ADDR_FLAGS, 8'h02, "flags cleared");
        expectReg(`ASML_ADDR_LANE, 8'h00, "lanes cleared");
        regWrite(`ASML_ADDR_FLAGS, 8'h00);
        expectReg(`ASML_ADDR_FLAGS, 8'h02, "zero write");
        endTest("clear");
        // Each cause sets its flag, which sticks and drives summary and pin once unmasked
        foreach (causeBits[i]) begin
            pulseCause(causeBits[i]);
            expectReg(`ASML_ADDR_FLAGS, 8'h02 | (8'h01 << causeBits[i]), "flag set");
            if (causeBits[i] == 5) begin
                expectReg(`ASML_ADDR_LANE, 8'h04, "lane bit");
            end
            regWrite(`ASML_ADDR_GATE, 8'h3f & ~(8'h01 << causeBits[i]));
            expectReg(`ASML_ADDR_SUMMARY, 8'h01, "summary up");
            check({7'h00, calibrationStatusPin}, 8'h01, "pin alarm");
            @(posedge ref_clk);
            calStatusSelAlarm <= 1'b0;
            repeat (2) @(posedge ref_clk);
            calStatusSelAlarm <= 1'b1;
            #1 check({7'h00, calibrationStatusPin}, 8'h00, "pin other");
            regWrite(`ASML_ADDR_GATE, 8'h3f);
            expectReg(`ASML_ADDR_SUMMARY, 8'h00, "summary masked");
            regWrite(`ASML_ADDR_FLAGS, 8'h01 << causeBits[i]);
            expectReg(`ASML_ADDR_FLAGS, 8'h02, "flag cleared");
            if (causeBits[i] == 5) begin
                expectReg(`ASML_ADDR_LANE, 8'h00, "lane cleared");
            end
        end
        endTest("events");
        // A persisting condition sets its flag again straight after the clear
        @(posedge ref_clk);
        setCause(4, 1'b1);
        regWrite(`ASML_ADDR_FLAGS, 8'h10);
        expectReg(`ASML_ADDR_FLAGS, 8'h12, "persist");
        @(posedge ref_clk);
        setCause(4, 1'b0);
        regWrite(`ASML_ADDR_FLAGS, 8'h10);
        expectReg(`ASML_ADDR_FLAGS, 8'h02, "persist gone");
        endTest("persist");
        // Clock flag stays live with the link off; 64B/66B startup and realign set link flag
        @(posedge ref_clk);
        serialLinkEnable <= 1'b0;
        linkMode64b66b <= 1'b1;
        pulseCause(0);
        expectReg(`ASML_ADDR_FLAGS, 8'h03, "clock while off");
        regWrite(`ASML_ADDR_FLAGS, 8'h01);
        @(posedge ref_clk);
        serialLinkEnable <= 1'b1;
        expectReg(`ASML_ADDR_FLAGS, 8'h0a, "startup");
        regWrite(`ASML_ADDR_FLAGS, 8'h08);
        expectReg(`ASML_ADDR_FLAGS, 8'h02, "startup once");
        pulseCause(6);
        expectReg(`ASML_ADDR_FLAGS, 8'h0a, "realign");
        endTest("link64");
        // Summary is read-only; unmapped places read zero
        regWrite(`ASML_ADDR_SUMMARY, 8'hff);
        expectReg(`ASML_ADDR_SUMMARY, 8'h00, "summary ro");
        expectReg(15'h2c3, 8'h00, "unmapped");
        endTest("read only");
        // Soft reset restores flags, gate and lanes
        @(posedge ref_clk);
        softReset <= 1'b1;
        @(posedge ref_clk);
        softReset <= 1'b0;
        expectReg(`ASML_ADDR_FLAGS, `ASML_RST_FLAGS, "soft flags");
        expectReg(`ASML_ADDR_GATE, `ASML_RST_GATE, "soft gate");
        expectReg(`ASML_ADDR_LANE, `ASML_RST_LANE, "soft lanes");
        endTest("soft reset");
        summarize();
    end
endmodule : asml_alarm_logic_tb
